// File: src/thms_pkg.sv
// Constants and types shared by the touch host mode select controller.
package thms_pkg;

    // Core clock rate in Hz.
    localparam int unsigned CLK_HZ            = 25000000;
    // Host bus release window while straps are sampled, in ms.
    localparam int unsigned BUS_RELEASE_MS    = 10;
    localparam int unsigned BUS_RELEASE_CYC   = (CLK_HZ / 1000) * BUS_RELEASE_MS;
    // Whole power-on sequence bound, in ms.
    localparam int unsigned POWER_ON_MS       = 350;
    localparam int unsigned POWER_ON_CYC      = (CLK_HZ / 1000) * POWER_ON_MS;
    // Width of the power-on counter.
    localparam int unsigned PWR_CNT_W         = 24;
    // Synchroniser depth; pin levels are valid this many counts after reset.
    localparam int unsigned SYNC_STAGES       = 2;
    // Strap codes for the protocol interface choice.
    localparam logic [2:0]  STRAP_SPI         = 3'h7;
    localparam logic [2:0]  STRAP_I2C         = 3'h3;
    // Reset values.
    localparam logic [2:0]  STRAP_RESET       = 3'h0;
    localparam logic [2:0]  KEY_OUT_RESET     = 3'h0;

    // Interface chosen at power-up.
    typedef enum logic [1:0] {
        THMS_IF_NONE,
        THMS_IF_SPI,
        THMS_IF_I2C
    } thms_if_t;

    // Power-on sequence states.
    typedef enum logic [2:0] {
        THMS_ST_INIT,
        THMS_ST_SAMPLE,
        THMS_ST_HELLO,
        THMS_ST_RUN,
        THMS_ST_SLEEP
    } thms_state_t;

endpackage

// File: src/thms_sync.sv
// Two-flip-flop synchroniser for a bundle of pin levels.
`timescale 1ns/1ps
module thms_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

// File: src/thms_ctrl.sv
// Mode select, power-on, request line and pin reuse logic of the touch key controller.
// Operation
// [R1] Request line low while a packet waits, high when idle and ready.
// [R2] Mode strap low selects protocol mode controlled over the serial link.
// [R3] Mode strap high selects direct key mode at once, no configuration; here direct mode starts only when done_reg sets at the end of power-on.
// [R4] Direct key mode reads the three select pins as variant inputs.
// [R5] Protocol mode samples select pins at power-on to choose I2C or SPI.
// [R6] After choice, select pins become clock, data in and SPI data out.
// [R7] Power save input low sleeps the device, high resumes operation.
// [R8] After initialisation a ready announcement packet goes to the host.
// [R9] Host releases the shared lines for 10 ms during strap sampling.
// [R10] Power-on sequence completes within 350 ms.
// [R11] Extra key pins act as key inputs or status outputs by mode.
// [R12] All select pins high picks SPI; select 2 low, others high, I2C.
// [R13] Key change pulls request low; high again after the transfer ends.
// [R14] Interface choice latches once at power-up, held until next reset.
`timescale 1ns/1ps
module thms_ctrl
    import thms_pkg::*;
#(
    parameter int unsigned RELEASE_CYC = BUS_RELEASE_CYC,
    parameter int unsigned PWR_ON_CYC  = POWER_ON_CYC
) (
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic       IO_PROTOCOL_SELECT,
    input  wire logic       POWER_SAVE_N,
    input  wire logic       INTERFACE_SELECT_0,
    input  wire logic       INTERFACE_SELECT_1,
    input  wire logic       INTERFACE_SELECT_2,
    output logic            INTERFACE_SELECT_2_OUT,
    output logic            INTERFACE_SELECT_2_OE,
    input  wire logic [2:0] TOUCH_KEY_INPUTS,
    input  wire logic [2:0] KEY_OR_STATUS_PINS_IN,
    output logic      [2:0] KEY_OR_STATUS_PINS_OUT,
    output logic      [2:0] KEY_OR_STATUS_PINS_OE,
    input  wire logic       KEY_EVENT,
    input  wire logic       TRANSFER_DONE,
    input  wire logic       SPI_SDO_DATA,
    input  wire logic [2:0] KEY_STATUS,
    output logic            HOST_REQUEST_N,
    output logic            READY_ANNOUNCE,
    output logic            PROTOCOL_MODE,
    output logic            DIRECT_KEY_MODE,
    output logic [2:0]      DIRECT_VARIANT,
    output logic            IF_SPI,
    output logic            IF_I2C,
    output logic            LINK_SCK,
    output logic            LINK_SDI,
    output logic            SLEEP,
    output logic            POWER_ON_DONE,
    output logic [5:0]      KEY_LEVELS
);

    // Counter span of the sampling window and the whole power-on bound.
    localparam logic [PWR_CNT_W-1:0] RELEASE_LAST = PWR_CNT_W'(RELEASE_CYC - 1);
    localparam logic [PWR_CNT_W-1:0] PWR_ON_LAST  = PWR_CNT_W'(PWR_ON_CYC - 1);
    // The mode strap is read only once the synchroniser holds a real pin level.
    localparam logic [PWR_CNT_W-1:0] SYNC_FILL    = PWR_CNT_W'(SYNC_STAGES);

    logic        rst_meta_reg;
    logic        rst_n_reg;
    logic        mode_s;
    logic        psave_s;
    logic [2:0]  sel_s;
    logic [2:0]  keys_s;
    logic [2:0]  xkeys_s;

    // Reset release is made synchronous so every flop leaves reset together.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // All pin levels cross into the core clock through two flops.
    thms_sync #(.WIDTH(11)) u_sync (
        .clk   (CLK),
        .rst_n (rst_n_reg),
        .d     ({IO_PROTOCOL_SELECT, POWER_SAVE_N, INTERFACE_SELECT_2, INTERFACE_SELECT_1,
                 INTERFACE_SELECT_0, TOUCH_KEY_INPUTS, KEY_OR_STATUS_PINS_IN}),
        .q     ({mode_s, psave_s, sel_s, keys_s, xkeys_s})
    );

    // Strap decode shared by the sampling step.
    function automatic thms_if_t decode_if(input logic [2:0] sel);
        thms_if_t r;
        r = THMS_IF_NONE;
        if (sel == STRAP_SPI) begin
            r = THMS_IF_SPI;
        end else if (sel == STRAP_I2C) begin
            r = THMS_IF_I2C;
        end
        return r;
    endfunction

    thms_state_t            state_reg, state_next;
    logic [PWR_CNT_W-1:0]   cnt_reg, cnt_next;
    thms_if_t               if_reg, if_next;
    logic                   proto_reg, proto_next;
    logic                   pend_reg, pend_next;
    logic                   hello_reg, hello_next;
    logic                   done_reg, done_next;

    // Power-on sequence: init, strap sample, hello packet, then run or sleep.
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        if_next    = if_reg;
        proto_next = proto_reg;
        pend_next  = pend_reg;
        hello_next = 1'b0;
        done_next  = done_reg;
        if (cnt_reg != PWR_ON_LAST && !done_reg) begin
            cnt_next = cnt_reg + 1'b1;
        end
        case (state_reg)
            THMS_ST_INIT: begin
                // [R2] [R3] mode strap capture
                // The synchroniser still shows its reset level for the first
                // counts, which would always read as protocol mode.
                if (cnt_reg >= SYNC_FILL) begin
                    proto_next = ~mode_s;
                    state_next = THMS_ST_SAMPLE;
                end
            end
            THMS_ST_SAMPLE: begin
                // [R9] host release window
                if (cnt_reg >= RELEASE_LAST) begin
                    // [R5] [R12] [R14] latch interface once
                    if (proto_reg) begin
                        if_next = decode_if(sel_s);
                    end
                    state_next = THMS_ST_HELLO;
                end
            end
            THMS_ST_HELLO: begin
                // [R8] [R10] ready announcement closes power-on
                if (cnt_reg == PWR_ON_LAST) begin
                    hello_next = proto_reg;
                    pend_next  = proto_reg;
                    done_next  = 1'b1;
                    state_next = THMS_ST_RUN;
                end
            end
            THMS_ST_RUN: begin
                // [R7] sleep entry
                if (!psave_s) begin
                    state_next = THMS_ST_SLEEP;
                end
            end
            THMS_ST_SLEEP: begin
                // [R7] wake on release
                if (psave_s) begin
                    state_next = THMS_ST_RUN;
                end
            end
            default: state_next = THMS_ST_INIT;
        endcase
        // [R13] key change raises a request; set wins over transfer end.
        // The hello request also beats a transfer end in the same cycle.
        if ((state_reg == THMS_ST_RUN && proto_reg && KEY_EVENT) || hello_next) begin
            pend_next = 1'b1;
        end else if (TRANSFER_DONE) begin
            pend_next = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= THMS_ST_INIT;
            cnt_reg   <= '0;
            if_reg    <= THMS_IF_NONE;
            proto_reg <= 1'b0;
            pend_reg  <= 1'b0;
            hello_reg <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            if_reg    <= if_next;
            proto_reg <= proto_next;
            pend_reg  <= pend_next;
            hello_reg <= hello_next;
            done_reg  <= done_next;
        end
    end

    logic [2:0] variant_reg, variant_next;
    logic [2:0] kout_reg, kout_next;
    logic       sdo_reg, sdo_next;

    // Pin reuse: in direct mode select pins are variant inputs and extra
    // pins carry key status; in protocol mode extra pins are key inputs.
    always_comb begin
        // [R4] variant follows pins only in direct key mode
        variant_next = (!proto_reg && done_reg) ? sel_s : variant_reg;
        // [R11] status outputs only in direct key mode
        kout_next    = (!proto_reg && done_reg) ? KEY_STATUS : KEY_OUT_RESET;
        // [R6] SPI data out drives select 2 pin
        sdo_next     = (if_reg == THMS_IF_SPI) ? SPI_SDO_DATA : 1'b0;
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            variant_reg <= STRAP_RESET;
            kout_reg    <= KEY_OUT_RESET;
            sdo_reg     <= 1'b0;
        end else begin
            variant_reg <= variant_next;
            kout_reg    <= kout_next;
            sdo_reg     <= sdo_next;
        end
    end

    // Outputs; the pin is released until the interface is SPI and power-on is done so the
    // strap level is never fought while it is being sampled.
    // [R1] request line from pending flag
    assign HOST_REQUEST_N         = ~pend_reg;
    assign READY_ANNOUNCE         = hello_reg;
    assign PROTOCOL_MODE          = proto_reg & done_reg;
    assign DIRECT_KEY_MODE        = ~proto_reg & done_reg;
    assign DIRECT_VARIANT         = variant_reg;
    assign IF_SPI                 = (if_reg == THMS_IF_SPI);
    assign IF_I2C                 = (if_reg == THMS_IF_I2C);
    // [R6] clock and data in routed from select pins
    assign LINK_SCK               = (if_reg != THMS_IF_NONE) ? sel_s[0] : 1'b0;
    assign LINK_SDI               = (if_reg != THMS_IF_NONE) ? sel_s[1] : 1'b0;
    assign INTERFACE_SELECT_2_OUT = sdo_reg;
    assign INTERFACE_SELECT_2_OE  = (if_reg == THMS_IF_SPI) & done_reg;
    assign KEY_OR_STATUS_PINS_OUT = kout_reg;
    assign KEY_OR_STATUS_PINS_OE  = {3{~proto_reg & done_reg}};
    assign SLEEP                  = (state_reg == THMS_ST_SLEEP);
    assign POWER_ON_DONE          = done_reg;
    assign KEY_LEVELS             = {(proto_reg ? xkeys_s : 3'h0), keys_s};

    // [R1] request low only in protocol mode
    chk_req_pending: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R1]
        !HOST_REQUEST_N |-> PROTOCOL_MODE) else $error("request line low outside protocol mode");
    // [R13] key event in run raises request next cycle
    chk_key_request: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R13]
        (state_reg == THMS_ST_RUN && proto_reg && KEY_EVENT) |=> !HOST_REQUEST_N)
        else $error("key change did not pull request low");
    // [R13] transfer end without a new request releases the line
    chk_req_release: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R13]
        (TRANSFER_DONE && !KEY_EVENT && !hello_next) |=> HOST_REQUEST_N) else $error("request not released");
    // [R14] interface choice never changes after power-on
    chk_if_locked: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R14]
        done_reg |=> $stable(if_reg)) else $error("interface choice changed");
    // [R12] SPI strap decodes to SPI
    chk_spi_decode: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R12]
        (state_reg == THMS_ST_SAMPLE && state_next == THMS_ST_HELLO && proto_reg && sel_s == STRAP_SPI)
        |=> IF_SPI) else $error("SPI strap not decoded");
    // [R12] I2C strap decodes to I2C
    chk_i2c_decode: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R12]
        (state_reg == THMS_ST_SAMPLE && state_next == THMS_ST_HELLO && proto_reg && sel_s == STRAP_I2C)
        |=> IF_I2C) else $error("I2C strap not decoded");
    // [R3] direct mode has no serial interface
    chk_direct_noif: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R3]
        DIRECT_KEY_MODE |-> (if_reg == THMS_IF_NONE)) else $error("direct mode picked an interface");
    // [R2] [R3] mode level follows the captured strap
    chk_mode_capture: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R2] [R3]
        (state_reg == THMS_ST_INIT && state_next == THMS_ST_SAMPLE) |=> (proto_reg == !$past(mode_s)))
        else $error("mode strap not captured");
    // [R8] hello pulse lasts one cycle and comes with completion
    chk_hello_pulse: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R8]
        READY_ANNOUNCE |-> done_reg ##1 !READY_ANNOUNCE) else $error("hello pulse malformed");
    // [R8] hello only in protocol mode
    chk_hello_proto: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R8]
        READY_ANNOUNCE |-> PROTOCOL_MODE) else $error("hello outside protocol mode");
    // [R10] power-on ends by the bound
    chk_power_bound: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R10]
        (cnt_reg == PWR_ON_LAST) |-> ##[0:2] done_reg) else $error("power-on overran");
    // [R7] sleep follows power save low on the next cycle
    chk_sleep_entry: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R7]
        (state_reg == THMS_ST_RUN && !psave_s) |=> SLEEP) else $error("sleep not entered");
    // [R7] wake follows power save high on the next cycle
    chk_sleep_wake: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R7]
        (state_reg == THMS_ST_SLEEP && psave_s) |=> !SLEEP) else $error("sleep not left");
    // [R7] no new request while asleep
    chk_sleep_quiet: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R7]
        (SLEEP && HOST_REQUEST_N) |=> HOST_REQUEST_N) else $error("request raised while asleep");
    // [R6] select 2 driven only as SPI output
    chk_sdo_drive: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R6]
        INTERFACE_SELECT_2_OE |-> IF_SPI) else $error("select 2 driven outside SPI");
    // [R6] SPI data reaches select 2 a cycle later
    chk_sdo_follow: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R6]
        IF_SPI |=> (INTERFACE_SELECT_2_OUT == $past(SPI_SDO_DATA))) else $error("SPI data not on select 2");
    // [R4] variant follows the select pins
    chk_variant_follow: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R4]
        DIRECT_KEY_MODE |=> (DIRECT_VARIANT == $past(sel_s))) else $error("variant does not follow pins");
    // [R11] status pins carry key status
    chk_status_out: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R11]
        DIRECT_KEY_MODE |=> (KEY_OR_STATUS_PINS_OUT == $past(KEY_STATUS))) else $error("key status not driven");
    // [R11] extra pins stay inputs
    chk_status_off: assert property (@(posedge CLK) disable iff (!rst_n_reg) // [R11]
        PROTOCOL_MODE |-> (KEY_OR_STATUS_PINS_OE == 3'h0)) else $error("extra pins driven in protocol mode");

endmodule

// File: bench/thms_host_model.sv
// Host master model on the shared select lines: straps, link clock and data.
`timescale 1ns/1ps
module thms_host_model (
    input  wire logic [2:0] strap,
    input  wire logic       drive,
    input  wire logic       frame,
    input  wire logic       sdo_oe,
    input  wire logic       sdo_out,
    output logic      [2:0] pins,
    output logic            sdi
);
    logic sck = 1'b1;
    int   nbit = 0;
    assign pins = {sdo_oe ? sdo_out : strap[2], drive ? sdi : strap[1], drive ? sck : strap[0]};
    initial sdi = 1'b0;
    // One frame is eight link clocks; the clock stands high between frames so no stray edge reaches the core.
    always @(posedge frame) begin
        #37;
        repeat (16) begin
            #160;
            sck = ~sck;
            nbit = nbit + 1;
            if (!sck)
                sdi = nbit[2] ^ nbit[1];
        end
    end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the touch host mode select controller.
`timescale 1ns/1ps
module testbench;
    localparam int unsigned REL = 20;
    localparam int unsigned PON = 60;
    logic       CLK = 1'b0;
    logic       RESET_N = 1'b0;
    logic       io_sel = 1'b0;
    logic       ps_n = 1'b1;
    logic [2:0] strap = 3'h7;
    logic       drive = 1'b0;
    logic       frame = 1'b0;
    logic [2:0] tin = 3'h0;
    logic [2:0] kin = 3'h0;
    logic       kev = 1'b0;
    logic       tdone = 1'b0;
    logic       sdo = 1'b0;
    logic [2:0] kst = 3'h0;
    logic [2:0] pins, ks_out, ks_oe, variant;
    logic [5:0] levels;
    logic       sdi, sel2_out, sel2_oe, req_n, hello, pmode, dmode, is_spi, is_i2c, sck_q, sdi_q, sleep, done;
    int         err_count = 0;
    int         n_checks = 0;
    int         seed = 37176;
    int         exp_req, proto, asleep, hello_cnt, sck_edges, r;

    thms_host_model host (.strap(strap), .drive(drive), .frame(frame), .sdo_oe(sel2_oe), .sdo_out(sel2_out),
        .pins(pins), .sdi(sdi));
    thms_ctrl #(.RELEASE_CYC(REL), .PWR_ON_CYC(PON)) uut (
        .CLK(CLK), .RESET_N(RESET_N), .IO_PROTOCOL_SELECT(io_sel), .POWER_SAVE_N(ps_n),
        .INTERFACE_SELECT_0(pins[0]), .INTERFACE_SELECT_1(pins[1]), .INTERFACE_SELECT_2(pins[2]),
        .INTERFACE_SELECT_2_OUT(sel2_out), .INTERFACE_SELECT_2_OE(sel2_oe), .TOUCH_KEY_INPUTS(tin),
        .KEY_OR_STATUS_PINS_IN(kin), .KEY_OR_STATUS_PINS_OUT(ks_out), .KEY_OR_STATUS_PINS_OE(ks_oe),
        .KEY_EVENT(kev), .TRANSFER_DONE(tdone), .SPI_SDO_DATA(sdo), .KEY_STATUS(kst),
        .HOST_REQUEST_N(req_n), .READY_ANNOUNCE(hello), .PROTOCOL_MODE(pmode), .DIRECT_KEY_MODE(dmode),
        .DIRECT_VARIANT(variant), .IF_SPI(is_spi), .IF_I2C(is_i2c), .LINK_SCK(sck_q), .LINK_SDI(sdi_q),
        .SLEEP(sleep), .POWER_ON_DONE(done), .KEY_LEVELS(levels));

    // Core clock at 25 MHz.
    initial begin
        forever #20 CLK = ~CLK;
    end
    // Hello pulses and link clock edges are counted as they happen.
    always @(posedge CLK)
        if (hello === 1'b1)
            hello_cnt = hello_cnt + 1;
    always @(posedge sck_q)
        sck_edges = sck_edges + 1;

    task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge CLK);
    endtask
    // Power-on with given straps; a missing done counts as a mismatch and ends the run.
    task automatic boot(input logic io, input logic [2:0] s);
        int cyc;
        cyc = 0;
        @(negedge CLK);
        RESET_N = 1'b0;
        io_sel = io;
        strap = s;
        drive = 1'b0;
        tick(3);
        hello_cnt = 0;
        RESET_N = 1'b1;
        while (done !== 1'b1 && cyc < PON + 20) begin
            tick(1);
            cyc = cyc + 1;
        end
        check("power_on_time", (cyc >= PON && cyc <= PON + 8), 1'b1);
        if (done !== 1'b1)
            conclude();
        proto = !io;
        exp_req = proto;
        asleep = 0;
        tick(3);
        check("hello_count", hello_cnt, proto);
        check("request_n", req_n, !exp_req);
        check("modes", {pmode, dmode}, {proto[0], io});
    endtask
    // Event pulses against the request model; a set wins over a clear.
    task automatic pulse(input logic ke, input logic td);
        @(negedge CLK);
        kev = ke;
        tdone = td;
        if (proto && !asleep)
            exp_req = ke ? 1 : (td ? 0 : exp_req);
        tick(1);
        kev = 1'b0;
        tdone = 1'b0;
        check("request_n", req_n, !exp_req);
    endtask

    initial begin
        boot(1'b0, 3'h7);
        check("if_choice", {is_spi, is_i2c, sel2_oe, ks_oe}, {3'b101, 3'h0});
        strap = 3'h0;
        tick(6);
        check("if_latched", {is_spi, is_i2c}, 2'b10);
        strap = 3'h7;
        pulse(1'b0, 1'b1);
        pulse(1'b1, 1'b0);
        pulse(1'b1, 1'b1);
        repeat (10) begin
            r = $random(seed);
            pulse(r[0], r[1]);
        end
        drive = 1'b1;
        sck_edges = 0;
        frame = 1'b1;
        tick(80);
        frame = 1'b0;
        tick(5);
        check("link_edges", sck_edges, 6'd8);
        check("link_lines", {sck_q, sdi_q}, {1'b1, sdi});
        for (int b = 0; b < 2; b++) begin
            sdo = b[0];
            r = $random(seed);
            tin = r[2:0];
            kin = r[5:3];
            tick(4);
            check("sdo_pin", pins[2], b[0]);
            check("key_levels", levels, {kin, tin});
        end
        pulse(1'b0, 1'b1);
        ps_n = 1'b0;
        tick(5);
        asleep = 1;
        check("sleep", sleep, 1'b1);
        pulse(1'b1, 1'b0);
        ps_n = 1'b1;
        tick(5);
        asleep = 0;
        check("sleep", sleep, 1'b0);
        pulse(1'b1, 1'b0);
        boot(1'b0, 3'h3);
        check("if_choice", {is_spi, is_i2c, sel2_oe}, 3'b010);
        boot(1'b0, 3'h5);
        check("if_choice", {is_spi, is_i2c}, 2'b00);
        repeat (2) begin
            r = $random(seed);
            boot(1'b1, r[2:0]);
            check("variant", variant, r[2:0]);
            strap = r[5:3];
            kst = r[8:6];
            tin = r[11:9];
            kin = r[14:12];
            tick(5);
            check("variant", variant, strap);
            check("key_out", {ks_oe, ks_out}, {3'h7, kst});
            check("key_levels", levels, {3'h0, tin});
            pulse(1'b1, 1'b0);
        end
        conclude();
    end
endmodule
